// file: logic/apsh_map.vh
// register layout and timing constants for the converter control block
`ifndef APSH_MAP_VH
`define APSH_MAP_VH
`define APSH_BIT_LATCH    0
`define APSH_BIT_TRIM     1
`define APSH_BIT_HOLD     2
`define APSH_BIT_SLEEP    3
`define APSH_BIT_PFAIL    5
`define APSH_BIT_TRIMERR  6
`define APSH_BIT_BUSY     7
`define APSH_AUX_RESET    8'h28
`define APSH_CLK_MHZ      40
`define APSH_SEQ_CYCLES   13'h1211
`define APSH_CONV_CYCLES  13'h0011
`define APSH_TRIM_CYCLES  (`APSH_SEQ_CYCLES - `APSH_CONV_CYCLES)
`define APSH_ACQ_NS       2500
`define APSH_ACQ_CYCLES   ((`APSH_ACQ_NS * `APSH_CLK_MHZ + 999) / 1000)
`endif

// file: logic/apsh_sync.v
// two-flop synchroniser for one level
`default_nettype none
module apsh_sync (
  input  wire mclk,
  input  wire sys_rst,
  input  wire d,
  output reg  q
);
  reg s1;
  always @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      s1 <= 1'b0;
      q  <= 1'b0;
    end else begin
      s1 <= d;
      q  <= s1;
    end
  end
endmodule
`default_nettype wire

// file: logic/apsh_ctrl.v
// sleep and sample/hold control of the multiplexed converter
// Summary of operation
// - storing one to the sleep bit enters sleep and the bit reads one while asleep.
// - in sleep the analog parts stop but result and aux access still work.
// - storing zero to the sleep bit, a calibrate pin low outside hold mode or a trim start bit ends sleep.
// - after a supply dip the aux register resets, calibration starts and sleep is set.
// - a store pulse while asleep runs one conversion and then returns to sleep.
// - storing trim start and sleep together calibrates, converts, sleeps in 4625 cycles.
// - after that sequence a valid result stays in the output registers.
// - leaving sleep or a single sleep conversion adds no cycles to conversion timing.
// - in hold mode a rising sample pin edge holds the input and starts conversion 2 to 3 cycles later.
// - in hold mode a store does not convert but latches the channel from the select pins.
// - a store to the aux register while idle starts a conversion, or calibration first if trim is set, at the store rising edge.
// - the aux register is selected with aux select and upper byte select both high.
`default_nettype none
`include "apsh_map.vh"
module apsh_ctrl (
  input  wire        mclk,
  input  wire        sys_rst,
  input  wire        supply_fail,
  input  wire        chip_sel_n,
  input  wire        fetch_n,
  input  wire        store_n,
  input  wire        aux_reg_select,
  input  wire        upper_byte_select,
  input  wire        channel_sel_lsb,
  input  wire        channel_sel_msb,
  input  wire        cal_sample_n,
  input  wire [7:0]  data_in,
  input  wire [11:0] sar_result,
  output reg  [7:0]  data_out,
  output reg         data_oe,
  output reg         busy_n,
  output reg         sleep_active,
  output reg         analog_en,
  output reg         hold_en,
  output reg  [1:0]  channel,
  output reg  [11:0] result
);
  localparam ST_IDLE = 2'h0;
  localparam ST_TRIM = 2'h1;
  localparam ST_CONV = 2'h2;

  reg  [1:0]  state;
  reg  [12:0] cnt;
  reg  [7:0]  aux;
  reg         once;
  reg         trim_err;
  reg         st_d;
  reg         cs_d;
  reg         pf_d;
  reg  [1:0]  ch_hold;
  reg  [7:0]  wr_data;
  reg         wr_aux_sel;
  reg         wr_upper;
  reg  [1:0]  wr_chan;
  wire        st_s;
  wire        cal_low_s;
  wire        pf_s;
  wire        aux_sel = aux_reg_select & upper_byte_select;
  // ===========================================================
  // input synchronisers
  // sync before edges
  apsh_sync u_st (.mclk(mclk), .sys_rst(sys_rst), .d(~(store_n | chip_sel_n)), .q(st_s));
  apsh_sync u_cs (.mclk(mclk), .sys_rst(sys_rst), .d(~cal_sample_n), .q(cal_low_s));
  apsh_sync u_pf (.mclk(mclk), .sys_rst(sys_rst), .d(supply_fail), .q(pf_s));
  // pin idles high: sync its low level so reset matches idle, no false edge
  wire cs_s       = ~cal_low_s;
  // ===========================================================
  // store capture
  // store fields held
  always @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      wr_data    <= 8'h00;
      wr_aux_sel <= 1'b0;
      wr_upper   <= 1'b0;
      wr_chan    <= 2'h0;
    end else if (~chip_sel_n & ~store_n) begin
      wr_data    <= data_in;
      wr_aux_sel <= aux_reg_select;
      wr_upper   <= upper_byte_select;
      wr_chan    <= {channel_sel_msb, channel_sel_lsb};
    end
  end

  wire store_rise = st_d & ~st_s;
  wire pin_rise   = cs_s & ~cs_d;
  wire pin_fall   = cs_d & ~cs_s;
  wire pf_rec     = pf_d & ~pf_s;
  wire hold_mode  = aux[`APSH_BIT_HOLD];
  wire aux_store  = store_rise & wr_aux_sel & wr_upper;
  wire idle       = (state == ST_IDLE);
  // ===========================================================
  // sequencer and aux register
  always @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      st_d     <= 1'b0;
      cs_d     <= 1'b1;
      pf_d     <= 1'b0;
      state    <= ST_TRIM;
      cnt      <= `APSH_TRIM_CYCLES;
      aux      <= `APSH_AUX_RESET;
      once     <= 1'b0;
      trim_err <= 1'b0;
      channel  <= 2'h0;
      ch_hold  <= 2'h0;
      result   <= 12'h000;
      hold_en  <= 1'b0;
    end else begin
      st_d <= st_s;
      cs_d <= cs_s;
      pf_d <= pf_s;
      if (store_rise & ~wr_aux_sel)
        ch_hold <= wr_chan;
      if (pf_rec) begin
        aux   <= `APSH_AUX_RESET;
        state <= ST_TRIM;
        cnt   <= `APSH_TRIM_CYCLES;
        once  <= 1'b0;
      end else begin
        case (state)
          ST_IDLE: begin
            if (aux_store) begin
              aux <= {3'h0, wr_data[`APSH_BIT_PFAIL] & aux[`APSH_BIT_PFAIL], 1'b0,
                      wr_data[`APSH_BIT_HOLD:`APSH_BIT_LATCH]};
              if (wr_data[`APSH_BIT_TRIM]) begin
                state <= ST_TRIM;
                cnt   <= `APSH_TRIM_CYCLES;
                once  <= wr_data[`APSH_BIT_SLEEP];
                aux[`APSH_BIT_SLEEP] <= 1'b0;
              end else begin
                aux[`APSH_BIT_SLEEP] <= wr_data[`APSH_BIT_SLEEP];
                state <= ST_CONV;
                cnt   <= `APSH_CONV_CYCLES;
                once  <= wr_data[`APSH_BIT_SLEEP];
              end
            end else if (!hold_mode & (pin_fall | ~cs_s)) begin
              aux[`APSH_BIT_SLEEP] <= 1'b0;
              state <= ST_TRIM;
              cnt   <= `APSH_TRIM_CYCLES;
              once  <= 1'b0;
            end else if (hold_mode & pin_rise) begin
              hold_en <= 1'b1;
              channel <= ch_hold;
              state   <= ST_CONV;
              cnt     <= `APSH_CONV_CYCLES;
              once    <= aux[`APSH_BIT_SLEEP];
              aux[`APSH_BIT_SLEEP] <= 1'b0;
            end else if (store_rise & ~wr_aux_sel & ~hold_mode) begin
              channel <= wr_chan;
              state   <= ST_CONV;
              cnt     <= `APSH_CONV_CYCLES;
              once    <= aux[`APSH_BIT_SLEEP];
              aux[`APSH_BIT_SLEEP] <= 1'b0;
            end
          end
          ST_TRIM: begin
            trim_err <= 1'b0;
            if (cnt == 13'h0001) begin
              state <= ST_CONV;
              cnt   <= `APSH_CONV_CYCLES;
            end else begin
              cnt <= cnt - 13'h0001;
            end
          end
          ST_CONV: begin
            if (cnt == 13'h0001) begin
              result  <= sar_result;
              hold_en <= 1'b0;
              state   <= ST_IDLE;
              if (once)
                aux[`APSH_BIT_SLEEP] <= 1'b1;
              once <= 1'b0;
            end else begin
              cnt <= cnt - 13'h0001;
            end
          end
          default: state <= ST_IDLE;
        endcase
      end
      if (pf_s)
        aux[`APSH_BIT_PFAIL] <= 1'b1;
    end
  end
  // ===========================================================
  // registered outputs
  always @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      data_out     <= 8'h00;
      data_oe      <= 1'b0;
      busy_n       <= 1'b0;
      sleep_active <= 1'b0;
      analog_en    <= 1'b0;
    end else begin
      data_oe  <= ~chip_sel_n & ~fetch_n & store_n;
      if (aux_sel)
        data_out <= {~idle, trim_err, aux[`APSH_BIT_PFAIL], 1'b0, aux[`APSH_BIT_SLEEP],
                     state == ST_TRIM, aux[`APSH_BIT_HOLD], aux[`APSH_BIT_LATCH]};
      else if (upper_byte_select)
        data_out <= {4'h0, result[11:8]};
      else
        data_out <= result[7:0];
      busy_n       <= idle;
      sleep_active <= aux[`APSH_BIT_SLEEP] & idle;
      analog_en    <= ~(aux[`APSH_BIT_SLEEP] & idle);
    end
  end
endmodule
`default_nettype wire

// file: testbench/apsh_ctrl_asserts.sv
// port assertions for the converter control block
`default_nettype none
`include "apsh_map.vh"
module apsh_ctrl_asserts (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic supply_fail,
  input wire logic chip_sel_n,
  input wire logic fetch_n,
  input wire logic store_n,
  input wire logic cal_sample_n,
  input wire logic data_oe,
  input wire logic busy_n,
  input wire logic sleep_active,
  input wire logic analog_en,
  input wire logic hold_en
);
  // =====
  // busy span counter
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);
  logic [12:0] low_cnt;
  logic        armed;
  always @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      low_cnt <= 13'h0000;
      armed   <= 1'b0;
    end else begin
      low_cnt <= busy_n ? 13'h0000 : low_cnt + 13'h0001;
      armed   <= armed | busy_n;
    end
  end
  sequence span_end; $rose(busy_n) && armed; endsequence
  sequence span_start; $fell(busy_n); endsequence
  chk_span_length: assert property (span_end |->
    low_cnt == `APSH_CONV_CYCLES || low_cnt == `APSH_SEQ_CYCLES) else $error("bad busy span");
  chk_span_minimum: assert property (span_start |-> !busy_n [*8]) else $error("short busy");
  chk_hold_start: assert property ($rose(hold_en) |-> ##[0:2] !busy_n) else $error("late start");
  chk_hold_cause: assert property ($rose(hold_en) |-> $past(cal_sample_n)) else $error("no edge");
  chk_fail_retrim: assert property ($fell(supply_fail) |-> ##[0:8] !busy_n) else $error("no trim");
  chk_sleep_quiet: assert property (sleep_active
    |-> !analog_en && busy_n) else $error("analog on in sleep");
  chk_analog_busy: assert property (!busy_n && armed
    |-> analog_en) else $error("analog off while converting");
  chk_read_enable: assert property (!$past(sys_rst)
    |-> data_oe == $past(!chip_sel_n && !fetch_n && store_n)) else $error("bad drive");
  chk_idle_float: assert property ($past(chip_sel_n) |-> !data_oe) else $error("drives idle");
endmodule
bind apsh_ctrl apsh_ctrl_asserts chk (.mclk, .sys_rst, .supply_fail, .chip_sel_n, .fetch_n,
  .store_n, .cal_sample_n, .data_oe, .busy_n, .sleep_active, .analog_en, .hold_en);
`default_nettype wire

// file: testbench/apsh_sar_model.sv
// converter core stand-in feeding the result input
`default_nettype none
module apsh_sar_model #(parameter logic [11:0] CODE = 12'h5A3) (
  input  wire logic        mclk,
  input  wire logic        busy_n,
  output var  logic [11:0] sar_result
);
  // each conversion returns the next code, so a stale result cannot pass
  logic [11:0] step   = 12'h000;
  logic        busy_q = 1'b0;
  always @(posedge mclk) begin
    busy_q <= busy_n;
    if (busy_n && !busy_q)
      step <= step + 12'h001;
    sar_result <= busy_n ? ~(CODE + step) : CODE + step;
  end
endmodule
`default_nettype wire

// file: testbench/apsh_ctrl_tb.sv
// self-checking bench for sleep and sample/hold control
`default_nettype none
`include "apsh_map.vh"
`define CK(a, b) begin checks_done++; if ((a) !== (b)) begin num_errors++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, a, b); end end
module apsh_ctrl_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic        mclk = 0, sys_rst = 1, supply_fail = 0, chip_sel_n = 1, fetch_n = 1, store_n = 1;
  logic        aux_reg_select = 0, upper_byte_select = 0, channel_sel_lsb = 0;
  logic        channel_sel_msb = 0, cal_sample_n = 1, data_oe, busy_n, sleep_active;
  logic        analog_en, hold_en;
  logic [7:0]  data_in = 8'h00, data_out, rd;
  logic [11:0] sar_result, result;
  logic [1:0]  channel;
  int          num_errors = 0, checks_done = 0, n;
  apsh_ctrl uut (.mclk, .sys_rst, .supply_fail, .chip_sel_n, .fetch_n, .store_n, .aux_reg_select,
    .upper_byte_select, .channel_sel_lsb, .channel_sel_msb, .cal_sample_n, .data_in, .sar_result,
    .data_out, .data_oe, .busy_n, .sleep_active, .analog_en, .hold_en, .channel, .result);
  apsh_sar_model sar (.mclk, .busy_n, .sar_result);
  always #12.5 mclk = ~mclk;
  // =====
  // port access and wait tasks
  task automatic cyc(input int k);
    repeat (k) @(posedge mclk);
  endtask
  task automatic acc(input logic w, input logic sel, input logic [7:0] d);
    @(posedge mclk);
    chip_sel_n        <= 1'b0;
    store_n           <= !w;
    fetch_n           <= w;
    aux_reg_select    <= sel;
    upper_byte_select <= sel;
    data_in           <= d;
    cyc(3);
    @(negedge mclk);
    rd = data_out;
    @(posedge mclk);
    chip_sel_n <= 1'b1;
    store_n    <= 1'b1;
    fetch_n    <= 1'b1;
    cyc(2);
  endtask
  task automatic tally_and_finish();
    if (num_errors == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // counts the cycles that busy stays low
  task automatic run(output int k);
    int t;
    k = 0;
    for (t = 0; t < 40 && busy_n === 1'b1; t++) @(negedge mclk);
    while (busy_n === 1'b0 && k < 6000) begin
      @(negedge mclk);
      k++;
    end
    @(posedge mclk);
    if (k >= 6000) begin
      num_errors++;
      tally_and_finish();
    end
  endtask
  initial begin
    cyc(20);
    sys_rst <= 1'b0;
    run(n);
    acc(0, 1, 8'h00);
    `CK(rd, `APSH_AUX_RESET)
    acc(1, 1, 8'h00);
    run(n);
    `CK(n, 17)
    `CK(sleep_active, 1'b0)
    acc(0, 1, 8'h00);
    `CK(rd, 8'h00)
    acc(1, 1, 8'h08);
    run(n);
    `CK(n, 17)
    acc(0, 1, 8'h00);
    `CK(rd, 8'h08)
    acc(1, 0, 8'h00);
    run(n);
    `CK(n, 17)
    `CK(sleep_active, 1'b1)
    acc(1, 1, 8'h0A);
    run(n);
    `CK(n, 4625)
    `CK(result, 12'h5A7)
    `CK(sleep_active, 1'b1)
    acc(1, 1, 8'h04);
    run(n);
    `CK(n, 17)
    cal_sample_n    <= 1'b0;
    channel_sel_msb <= 1'b1;
    acc(1, 0, 8'h00);
    run(n);
    `CK(n, 0)
    cyc(100);
    cal_sample_n <= 1'b1;
    run(n);
    `CK(n, 17)
    `CK(channel, 2'h2)
    `CK(result, 12'h5A9)
    supply_fail <= 1'b1;
    cyc(4);
    supply_fail <= 1'b0;
    run(n);
    `CK(n, 4625)
    acc(0, 1, 8'h00);
    `CK(rd, `APSH_AUX_RESET)
    cal_sample_n <= 1'b0;
    cyc(4);
    cal_sample_n <= 1'b1;
    run(n);
    `CK(n, 4625)
    `CK(sleep_active, 1'b0)
    acc(0, 1, 8'h00);
    `CK(rd, 8'h20)
    tally_and_finish();
  end
endmodule
`default_nettype wire
